// file: rx_sig_pkg.sv
//==========================================================
// Contract
// - Payload read fills access data register.
// - Snapshot holds first frame signaling per multiframe.
// - Trunk conditioning global or per channel.
// - Replace select per channel or trunk code.
// - Replace with A-law or mu-law milliwatt.
// - Position select keeps two upper nibble bits; code masks only in ESF and SLC96 formats.
// - Force enable fixes ABCD to chosen level; code forces only while framed.
// - Payload enable off disables payload control.
// - Hold keeps stored ABCD unchanged.
// - Filter needs two identical codewords.
// - Irq enable gates change flags onto interrupt.
// - Four-state mode stores only A and B.
// - Sixteen-state default stores A, B, C, D.
// - Busy high during access; host waits.
// - Access control: read flag, seven-bit address.
// - Buffer read fills access data register.
// - Change sets flag; write one clears.
// - First two flag registers map channels 1 to 16.
// - Third flag register maps channels 17 to 24.
// - Buffer addresses 01h-18h are channels 1-24.
//==========================================================
package rx_sig_pkg;
    // Sizes of the block.
    localparam int NUM_LINKS = 2;
    localparam int NUM_CH = 24;
    localparam int NUM_BANKS = 3;
    // Register offsets within one link.
    localparam logic [7:0] OFS_PAY_STAT = 8'hcd;
    localparam logic [7:0] OFS_PAY_CTRL = 8'hce;
    localparam logic [7:0] OFS_PAY_DATA = 8'hcf;
    localparam logic [7:0] OFS_PAY_CFG = 8'hd0;
    localparam logic [7:0] OFS_PAY_EN = 8'hd1;
    localparam logic [7:0] OFS_SIG_CFG = 8'hd2;
    localparam logic [7:0] OFS_SIG_STAT = 8'hd3;
    localparam logic [7:0] OFS_SIG_CTRL = 8'hd4;
    localparam logic [7:0] OFS_SIG_DATA = 8'hd5;
    localparam logic [7:0] OFS_CHG0 = 8'hd6;
    localparam logic [7:0] OFS_CHG1 = 8'hd7;
    localparam logic [7:0] OFS_CHG2 = 8'hd8;
    // Reset values and writable masks.
    localparam logic [7:0] PAY_CFG_RST = 8'h80;
    localparam logic [7:0] PAY_CFG_MASK = 8'hc7;
    localparam logic [7:0] PAY_EN_MASK = 8'h0f;
    localparam logic [7:0] SIG_CFG_RST = 8'h01;
    localparam logic [7:0] SIG_CFG_MASK = 8'h0f;
    // Field positions.
    localparam int SNAP_BIT = 7;
    localparam int GTRK_BIT = 6;
    localparam int GSUB_LSB = 0;
    localparam int POSSEL_BIT = 3;
    localparam int FORCE_BIT = 2;
    localparam int LEVEL_BIT = 1;
    localparam int PAYLOAD_CONTROL_ENABLE_BIT = 0;
    localparam int FREEZE_BIT = 3;
    localparam int FILTER_BIT = 2;
    localparam int IRQEN_BIT = 1;
    localparam int STATE16_BIT = 0;
    localparam int RNW_BIT = 7;
    localparam int STRK_BIT = 4;
    localparam int PER_CHANNEL_REPLACE_SELECT_LSB = 5;
    // Indirect address pieces and banks.
    localparam logic [4:0] IDX_FIRST = 5'h01;
    localparam logic [4:0] IDX_LAST = 5'h18;
    localparam logic [1:0] BANK_PER_CHANNEL_REPLACE_SELECT = 2'h0;
    localparam logic [1:0] BANK_DATA_TRUNK_CODE = 2'h1;
    localparam logic [1:0] BANK_STRK = 2'h2;
    // Frame numbers inside the signaling multiframe.
    localparam logic [4:0] FRM_FIRST = 5'h01;
    localparam logic [4:0] FRM_A = 5'h06;
    localparam logic [4:0] FRM_B = 5'h0c;
    localparam logic [4:0] FRM_C = 5'h12;
    localparam logic [4:0] FRM_D = 5'h18;
    // Mask that keeps only the two upper signaling positions.
    localparam logic [3:0] AB_ONLY = 4'hc;
    // Eight-byte digital milliwatt sequences, byte 0 in the low bits.
    localparam logic [63:0] ALAW_MW = 64'hb4a1a1b4_34212134;
    localparam logic [63:0] MULAW_MW = 64'h9e8b8b9e_1e0b0b1e;
    // Replacement codes.
    typedef enum logic [2:0] {
        REPL_NONE = 3'h0,
        REPL_TRUNK = 3'h1,
        REPL_ALAW = 3'h2,
        REPL_MULAW = 3'h3
    } repl_t;
    // Framing formats reported by the framer.
    typedef enum logic [1:0] {
        FMT_NONE = 2'h0,
        FMT_SF = 2'h1,
        FMT_ESF = 2'h2,
        FMT_SLC96 = 2'h3
    } fmt_t;
endpackage

// file: rx_payload_signaling.sv
`timescale 1ns/1ps
module rx_payload_signaling (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_B,
    // Register port; ADDR[8] picks the link.
    input wire logic [8:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Received channel stream from the framer.
    input wire logic RX_VALID,
    input wire logic RX_LINK,
    input wire logic [4:0] RX_CH,
    input wire logic [4:0] RX_FRAME,
    input wire logic [7:0] RX_DATA,
    input wire logic [1:0] RX_SYNC,
    input wire logic [1:0][1:0] RX_FMT,
    // Processed channel stream, one lane per link.
    output logic [1:0] OUT_VALID,
    output logic [1:0][4:0] OUT_CH,
    output logic [1:0][7:0] OUT_DATA,
    output logic [1:0][3:0] RX_SIGNALING_OUTPUT,
    // Interrupt, active high level.
    output logic INT
);

    // Per-link read data and interrupt requests.
    logic [1:0][7:0] rdata_l;
    logic [1:0] irq_l;

    //==========================================================
    // Shared outputs
    //==========================================================
    // Unselected links return zero, so an OR merges them.
    assign RDATA = rdata_l[0] | rdata_l[1];
    // Any link with an enabled pending flag drives the interrupt.
    assign INT = |irq_l;

    //==========================================================
    // One independent copy per link
    //==========================================================
    // per link copy
    for (genvar l = 0; l < rx_sig_pkg::NUM_LINKS; l++) begin : g_link
        // Bus decode for this link.
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] ofs;
        // Direct registers.
        logic [7:0] pay_cfg_q;
        logic [7:0] pay_en_q;
        logic [7:0] sig_cfg_q;
        logic [7:0] pay_ctrl_q;
        logic [7:0] pay_data_q;
        logic [7:0] sig_ctrl_q;
        logic [7:0] sig_data_q;
        logic pay_busy_q;
        logic sig_busy_q;
        logic [23:0] chg_q;
        logic [23:0] chg_d;
        logic [7:0] rdata_q;
        logic [7:0] rmux;
        // Indirect stores: payload banks and signaling buffer.
        logic [7:0] pay_mem [rx_sig_pkg::NUM_BANKS*rx_sig_pkg::NUM_CH];
        logic [3:0] sig_mem [rx_sig_pkg::NUM_CH];
        logic [3:0] prev_cw [rx_sig_pkg::NUM_CH];
        logic [2:0] acc [rx_sig_pkg::NUM_CH];
        logic [3:0] snap [rx_sig_pkg::NUM_CH];
        // Indirect address decode.
        logic pay_ok;
        logic [6:0] pay_idx;
        logic sig_ok;
        logic [4:0] sig_idx;
        // Stream decode.
        logic hit;
        logic framed;
        logic esf;
        logic last;
        logic [3:0] cw;
        logic upd;
        logic changed;
        logic [3:0] sig_o;
        logic [7:0] data_o;
        logic [2:0] rsel;
        logic [7:0] per_channel_replace_select;
        logic [7:0] data_trunk_code;
        logic [7:0] strk;

        assign sel = (ADDR[8] == 1'(l));
        assign wr = WR && sel;
        assign rd = RD && sel;
        assign ofs = ADDR[7:0];

        // Payload indirect address: bank in [6:5], channel in [4:0].
        assign pay_ok = (pay_ctrl_q[4:0] >= rx_sig_pkg::IDX_FIRST)
            && (pay_ctrl_q[4:0] <= rx_sig_pkg::IDX_LAST)
            && (pay_ctrl_q[6:5] != 2'h3);
        assign pay_idx = 7'(pay_ctrl_q[6:5] * 7'(rx_sig_pkg::NUM_CH)
            + pay_ctrl_q[4:0] - rx_sig_pkg::IDX_FIRST);
        assign sig_ok = (sig_ctrl_q[6:0] >= 7'(rx_sig_pkg::IDX_FIRST))
            && (sig_ctrl_q[6:0] <= 7'(rx_sig_pkg::IDX_LAST));
        assign sig_idx = sig_ctrl_q[4:0] - rx_sig_pkg::IDX_FIRST;

        //==========================================================
        // Configuration registers
        //==========================================================
        // Software writes; reserved bits are held at zero.
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                pay_cfg_q <= rx_sig_pkg::PAY_CFG_RST;
                pay_en_q <= 8'h00;
                sig_cfg_q <= rx_sig_pkg::SIG_CFG_RST;
                pay_ctrl_q <= 8'h00;
                sig_ctrl_q <= 8'h00;
            end else if (wr) begin
                unique case (ofs)
                    rx_sig_pkg::OFS_PAY_CFG: pay_cfg_q <= WDATA & rx_sig_pkg::PAY_CFG_MASK;
                    rx_sig_pkg::OFS_PAY_EN: pay_en_q <= WDATA & rx_sig_pkg::PAY_EN_MASK;
                    rx_sig_pkg::OFS_SIG_CFG: sig_cfg_q <= WDATA & rx_sig_pkg::SIG_CFG_MASK;
                    rx_sig_pkg::OFS_PAY_CTRL: pay_ctrl_q <= WDATA;
                    rx_sig_pkg::OFS_SIG_CTRL: sig_ctrl_q <= WDATA;
                    default: ;
                endcase
            end
        end

        //==========================================================
        // Indirect access engines
        //==========================================================
        // Busy is high for the one cycle in which the access runs.
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                pay_busy_q <= 1'b0;
                sig_busy_q <= 1'b0;
            end else begin
                pay_busy_q <= wr && (ofs == rx_sig_pkg::OFS_PAY_CTRL);
                sig_busy_q <= wr && (ofs == rx_sig_pkg::OFS_SIG_CTRL);
            end
        end

        // Data registers take host writes or indirect read results.
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                pay_data_q <= 8'h00;
                sig_data_q <= 8'h00;
            end else begin
                if (pay_busy_q && pay_ctrl_q[rx_sig_pkg::RNW_BIT]) begin
                    pay_data_q <= pay_ok ? pay_mem[pay_idx] : 8'h00;
                end else if (wr && ofs == rx_sig_pkg::OFS_PAY_DATA) begin
                    pay_data_q <= WDATA;
                end
                if (sig_busy_q && sig_ctrl_q[rx_sig_pkg::RNW_BIT]) begin
                    sig_data_q <= sig_ok ? {4'h0, sig_mem[sig_idx]} : 8'h00;
                end else if (wr && ofs == rx_sig_pkg::OFS_SIG_DATA) begin
                    sig_data_q <= WDATA;
                end
            end
        end

        // Payload banks are written only by the indirect engine.
        always_ff @(posedge MCLK) begin
            if (pay_busy_q && !pay_ctrl_q[rx_sig_pkg::RNW_BIT] && pay_ok) begin
                pay_mem[pay_idx] <= pay_data_q;
            end
        end

        //==========================================================
        // Signaling extraction
        //==========================================================
        assign hit = RX_VALID && (RX_LINK == 1'(l))
            && (RX_CH < 5'(rx_sig_pkg::NUM_CH));
        assign framed = RX_SYNC[l] && (RX_FMT[l] != rx_sig_pkg::FMT_NONE);
        assign esf = (RX_FMT[l] == rx_sig_pkg::FMT_ESF)
            || (RX_FMT[l] == rx_sig_pkg::FMT_SLC96);
        assign last = hit && framed
            && (RX_FRAME == (esf ? rx_sig_pkg::FRM_D : rx_sig_pkg::FRM_B));

        // Complete codeword as A,B,C,D in bits 3..0.
        always_comb begin
            if (!esf) begin
                cw = {acc[RX_CH][2], RX_DATA[0], acc[RX_CH][2], RX_DATA[0]};
            end else if (sig_cfg_q[rx_sig_pkg::STATE16_BIT]) begin
                cw = {acc[RX_CH], RX_DATA[0]};
            end else begin
                cw = {acc[RX_CH][2], RX_DATA[0], 2'b00};
            end
        end

        assign upd = last && !sig_cfg_q[rx_sig_pkg::FREEZE_BIT]
            && (!sig_cfg_q[rx_sig_pkg::FILTER_BIT] || cw == prev_cw[RX_CH]);
        assign changed = upd && (cw != sig_mem[RX_CH]);

        // Collects A, B and C bits as their frames pass.
        always_ff @(posedge MCLK) begin
            if (hit && framed) begin
                if (RX_FRAME == rx_sig_pkg::FRM_A) begin
                    acc[RX_CH][2] <= RX_DATA[0];
                end
                if (RX_FRAME == rx_sig_pkg::FRM_B && esf) begin
                    acc[RX_CH][1] <= RX_DATA[0];
                end
                if (RX_FRAME == rx_sig_pkg::FRM_C) begin
                    if (sig_cfg_q[rx_sig_pkg::STATE16_BIT]) begin
                        acc[RX_CH][0] <= RX_DATA[0];
                    end else begin
                        acc[RX_CH][2] <= RX_DATA[0];
                    end
                end
                if (RX_FRAME == rx_sig_pkg::FRM_FIRST) begin
                    snap[RX_CH] <= sig_mem[RX_CH];
                end
            end
            if (last) begin
                prev_cw[RX_CH] <= cw;
            end
        end

        // Stored signaling; a host write wins on the same entry.
        always_ff @(posedge MCLK) begin
            if (upd) begin
                sig_mem[RX_CH] <= cw;
            end
            if (sig_busy_q && !sig_ctrl_q[rx_sig_pkg::RNW_BIT] && sig_ok) begin
                sig_mem[sig_idx] <= sig_data_q[3:0];
            end
        end

        //==========================================================
        // Change flags
        //==========================================================
        // set wins over clear
        always_comb begin
            chg_d = chg_q;
            if (wr && ofs == rx_sig_pkg::OFS_CHG0) begin
                chg_d[7:0] = chg_q[7:0] & ~WDATA;
            end
            if (wr && ofs == rx_sig_pkg::OFS_CHG1) begin
                chg_d[15:8] = chg_q[15:8] & ~WDATA;
            end
            if (wr && ofs == rx_sig_pkg::OFS_CHG2) begin
                chg_d[23:16] = chg_q[23:16] & ~WDATA;
            end
            if (changed) begin
                chg_d[RX_CH] = 1'b1;
            end
        end

        // Flag register.
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                chg_q <= 24'h000000;
            end else begin
                chg_q <= chg_d;
            end
        end

        assign irq_l[l] = sig_cfg_q[rx_sig_pkg::IRQEN_BIT] && (|chg_q);

        //==========================================================
        // Payload and signaling output
        //==========================================================
        assign per_channel_replace_select = pay_mem[RX_CH];
        assign data_trunk_code = pay_mem[7'(rx_sig_pkg::BANK_DATA_TRUNK_CODE) * 7'(rx_sig_pkg::NUM_CH) + 7'(RX_CH)];
        assign strk = pay_mem[7'(rx_sig_pkg::BANK_STRK) * 7'(rx_sig_pkg::NUM_CH) + 7'(RX_CH)];

        // Chooses replacement data and signaling for this channel.
        always_comb begin
            rsel = pay_cfg_q[rx_sig_pkg::GSUB_LSB +: 3];
            if (rsel == rx_sig_pkg::REPL_NONE) begin
                rsel = per_channel_replace_select[rx_sig_pkg::PER_CHANNEL_REPLACE_SELECT_LSB +: 3];
            end
            unique case (rsel)
                rx_sig_pkg::REPL_TRUNK: data_o = data_trunk_code;
                rx_sig_pkg::REPL_ALAW: data_o = rx_sig_pkg::ALAW_MW[8*RX_FRAME[2:0] +: 8];
                rx_sig_pkg::REPL_MULAW: data_o = rx_sig_pkg::MULAW_MW[8*RX_FRAME[2:0] +: 8];
                default: data_o = RX_DATA;
            endcase
            if (pay_cfg_q[rx_sig_pkg::SNAP_BIT] && framed && RX_FRAME != rx_sig_pkg::FRM_FIRST) begin
                sig_o = snap[RX_CH];
            end else begin
                sig_o = sig_mem[RX_CH];
            end
            if (esf && pay_en_q[rx_sig_pkg::POSSEL_BIT]) begin
                sig_o = sig_o & rx_sig_pkg::AB_ONLY;
            end
            if (pay_cfg_q[rx_sig_pkg::GTRK_BIT] || strk[rx_sig_pkg::STRK_BIT]) begin
                sig_o = strk[3:0];
            end
            if (framed && pay_en_q[rx_sig_pkg::FORCE_BIT]) begin
                sig_o = {4{pay_en_q[rx_sig_pkg::LEVEL_BIT]}};
            end
            if (!pay_en_q[rx_sig_pkg::PAYLOAD_CONTROL_ENABLE_BIT]) begin
                data_o = RX_DATA;
                sig_o = sig_mem[RX_CH];
            end
        end

        // Output stage, one cycle after the input channel.
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                OUT_VALID[l] <= 1'b0;
                OUT_CH[l] <= 5'h00;
                OUT_DATA[l] <= 8'h00;
                RX_SIGNALING_OUTPUT[l] <= 4'h0;
            end else begin
                OUT_VALID[l] <= hit;
                if (hit) begin
                    OUT_CH[l] <= RX_CH;
                    OUT_DATA[l] <= data_o;
                    RX_SIGNALING_OUTPUT[l] <= sig_o;
                end
            end
        end

        //==========================================================
        // Register read back
        //==========================================================
        // Read mux of the direct registers.
        always_comb begin
            unique case (ofs)
                rx_sig_pkg::OFS_PAY_STAT: rmux = {7'h00, pay_busy_q};
                rx_sig_pkg::OFS_PAY_CTRL: rmux = pay_ctrl_q;
                rx_sig_pkg::OFS_PAY_DATA: rmux = pay_data_q;
                rx_sig_pkg::OFS_PAY_CFG: rmux = pay_cfg_q;
                rx_sig_pkg::OFS_PAY_EN: rmux = pay_en_q;
                rx_sig_pkg::OFS_SIG_CFG: rmux = sig_cfg_q;
                rx_sig_pkg::OFS_SIG_STAT: rmux = {7'h00, sig_busy_q};
                rx_sig_pkg::OFS_SIG_CTRL: rmux = sig_ctrl_q;
                rx_sig_pkg::OFS_SIG_DATA: rmux = sig_data_q;
                rx_sig_pkg::OFS_CHG0: rmux = chg_q[7:0];
                rx_sig_pkg::OFS_CHG1: rmux = chg_q[15:8];
                rx_sig_pkg::OFS_CHG2: rmux = chg_q[23:16];
                default: rmux = 8'h00;
            endcase
        end

        // Read data stands for the one cycle after the strobe.
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                rdata_q <= 8'h00;
            end else begin
                rdata_q <= rd ? rmux : 8'h00;
            end
        end
        assign rdata_l[l] = rdata_q;
    end

endmodule

// file: rx_payload_signaling_properties.sv
`timescale 1ns/1ps
//==========================================================
// Port watcher for the receive payload and signaling block.
module rx_payload_signaling_checker (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_B,
    // Register port.
    input wire logic [8:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Channel stream and interrupt.
    input wire logic RX_VALID,
    input wire logic RX_LINK,
    input wire logic [4:0] RX_CH,
    input wire logic [1:0] OUT_VALID,
    input wire logic [1:0][4:0] OUT_CH,
    input wire logic [1:0][3:0] RX_SIGNALING_OUTPUT,
    input wire logic INT
);
    // One clock domain, so one clocking and one reset for all checks.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);
    property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_busy_on; WR && ADDR[7:0] == 8'hd4 ##1 RD && ADDR[7:0] == 8'hd3 && ADDR[8] == $past(ADDR[8]) |=> RDATA == 8'h01; endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy missing");
    property p_busy_off; RD && ADDR[7:0] == 8'hd3 && !$past(WR) |=> RDATA == 8'h00; endproperty
    a_busy_off: assert property (p_busy_off) else $error("busy stuck");
    property p_stat_rsv; RD && ADDR[7:0] == 8'hd3 |=> RDATA[7:1] == 7'h00; endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits set");
    property p_out_lane; RX_VALID && RX_CH < 5'd24 |=> OUT_VALID[$past(RX_LINK)] && OUT_CH[$past(RX_LINK)] == $past(RX_CH); endproperty
    a_out_lane: assert property (p_out_lane) else $error("hit missing on lane");
    property p_no_hit; !RX_VALID || RX_CH > 5'd23 |=> OUT_VALID == 2'b00; endproperty
    a_no_hit: assert property (p_no_hit) else $error("output without hit");
    property p_sig_hold; !OUT_VALID[0] |-> $stable(RX_SIGNALING_OUTPUT[0]); endproperty
    a_sig_hold: assert property (p_sig_hold) else $error("signaling moved");
    property p_int_cause; $rose(INT) |-> $past(RX_VALID) || $past(WR); endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");
endmodule

bind rx_payload_signaling rx_payload_signaling_checker chk (
    .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_VALID(RX_VALID), .RX_LINK(RX_LINK), .RX_CH(RX_CH), .OUT_VALID(OUT_VALID),
    .OUT_CH(OUT_CH), .RX_SIGNALING_OUTPUT(RX_SIGNALING_OUTPUT), .INT(INT)
);

// file: rx_framer_model.sv
`timescale 1ns/1ps
//==========================================================
// Framer side: one channel byte per clock, both links in sync.
module rx_framer_model (
    // Clock.
    input wire logic clk,
    // Channel stream toward the block.
    output logic rx_valid,
    output logic rx_link,
    output logic [4:0] rx_ch,
    output logic [4:0] rx_frame,
    output logic [7:0] rx_data,
    output logic [1:0] rx_sync,
    output logic [1:0][1:0] rx_fmt
);
    // Both links report synchronized extended superframe.
    initial begin
        rx_valid = 1'b0;
        rx_link = 1'b0;
        rx_ch = 5'd0;
        rx_frame = 5'd1;
        rx_data = 8'h00;
        rx_sync = 2'b11;
        rx_fmt = {2{rx_sig_pkg::FMT_ESF}};
    end
    // Present one byte, called just after a rising edge.
    task automatic drive(input logic l, input logic [4:0] c, f, input logic [7:0] d);
        rx_valid <= 1'b1;
        rx_link <= l;
        rx_ch <= c;
        rx_frame <= f;
        rx_data <= d;
        @(posedge clk);
    endtask
    // Release the lane; data flips so a stale byte never looks valid.
    task automatic rest();
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge clk);
    endtask
    task automatic send_mf(input logic l, input logic [4:0] c, input logic [3:0] code);
        for (int f = 1; f <= 24; f++) begin
            drive(l, c, 5'(f), {7'h2a, (f % 6 == 0) ? code[4 - f / 6] : 1'b0});
        end
        rest();
    endtask
endmodule

// file: test_rx_payload_signaling_control.sv
`timescale 1ns/1ps
//==========================================================
// Self-checking bench for the receive payload and signaling block.
module test_rx_payload_signaling_control;
    // Design ports, every input given a value at time zero.
    logic MCLK = 1'b0;
    logic RST_B = 1'b0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [8:0] ADDR = 9'h000;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic RX_VALID, RX_LINK, INT;
    logic [4:0] RX_CH, RX_FRAME;
    logic [7:0] RX_DATA;
    logic [1:0] RX_SYNC, OUT_VALID;
    logic [1:0][1:0] RX_FMT;
    logic [1:0][4:0] OUT_CH;
    logic [1:0][7:0] OUT_DATA;
    logic [1:0][3:0] RX_SIGNALING_OUTPUT;
    // Counters and captured values.
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] got, out_q, sig_q;
    // Rows: write flag, address, write data, expected read value.
    logic [25:0] rows [8] = '{{1'b0, 9'h0d0, 8'h00, 8'h80}, {1'b0, 9'h0d2, 8'h00, 8'h01},
        {1'b1, 9'h1d0, 8'hff, 8'hc7}, {1'b0, 9'h0d0, 8'h00, 8'h80},
        {1'b1, 9'h0d1, 8'hff, 8'h0f}, {1'b1, 9'h0e0, 8'hff, 8'h00},
        {1'b1, 9'h0d1, 8'h00, 8'h00}, {1'b1, 9'h0d2, 8'h03, 8'h03}};
    logic [4:0] chs [3] = '{5'd2, 5'd8, 5'd16};
    logic [3:0] codes [3] = '{4'ha, 4'h5, 4'hf};
    logic [23:0] modes [4] = '{24'h81013c, {16'h8201, rx_sig_pkg::ALAW_MW[31:24]},
        {16'h8301, rx_sig_pkg::MULAW_MW[31:24]}, 24'h810011};
    // Rows: configuration, control enable, expected signaling of channel 3.
    logic [23:0] sigs [6] = '{24'h81070f, 24'h810500, 24'h81010a, 24'h01090c,
        24'h410106, 24'h41000f};
    rx_payload_signaling dut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_LINK(RX_LINK),
        .RX_CH(RX_CH), .RX_FRAME(RX_FRAME), .RX_DATA(RX_DATA), .RX_SYNC(RX_SYNC),
        .RX_FMT(RX_FMT), .OUT_VALID(OUT_VALID), .OUT_CH(OUT_CH), .OUT_DATA(OUT_DATA),
        .RX_SIGNALING_OUTPUT(RX_SIGNALING_OUTPUT), .INT(INT));
    rx_framer_model frm (.clk(MCLK), .rx_valid(RX_VALID), .rx_link(RX_LINK), .rx_ch(RX_CH),
        .rx_frame(RX_FRAME), .rx_data(RX_DATA), .rx_sync(RX_SYNC), .rx_fmt(RX_FMT));
    // Clock at 200 MHz.
    always #2.5 MCLK = ~MCLK;
    // Capture lane 0 while its output stands.
    always @(negedge MCLK) begin
        if (OUT_VALID[0] === 1'b1) begin
            out_q = OUT_DATA[0];
            sig_q = {4'h0, RX_SIGNALING_OUTPUT[0]};
        end
    end
    // Cut a hang short.
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    // One register-port cycle, changed just after a rising edge.
    task automatic op(input logic w, r, input logic [8:0] a, input logic [7:0] d);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, a, d);
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [8:0] a);
        op(1'b0, 1'b1, a, 8'h00);
        RD <= 1'b0;
        @(negedge MCLK);
        got = RDATA;
        @(posedge MCLK);
    endtask
    // Indirect read of a buffer entry; data is ready two cycles on.
    task automatic ind_rd(input logic [4:0] c);
        wr(9'h0d4, {3'h4, c} + 8'h01);
        rd(9'h0d5);
    endtask
    task automatic chk(input logic [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge MCLK);
        RST_B <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][25]) wr(rows[i][24:16], rows[i][15:8]);
            rd(rows[i][24:16]);
            chk(got, rows[i][7:0]);
        end
        op(1'b1, 1'b0, 9'h0d4, 8'h83);
        rd(9'h0d3);
        chk(got, 8'h01);
        rd(9'h0d3);
        chk(got, 8'h00);
        // Clear each entry, then a codeword sets its change flag.
        foreach (chs[i]) begin
            op(1'b1, 1'b0, 9'h0d5, 8'h00);
            wr(9'h0d4, {3'h0, chs[i]} + 8'h01);
            frm.send_mf(1'b0, chs[i], codes[i]);
            rd(9'h0d6 + 9'(chs[i][4:3]));
            chk(got, 8'h01 << chs[i][2:0]);
            ind_rd(chs[i]);
            chk(got, {4'h0, codes[i]});
        end
        chk({7'h00, INT}, 8'h01);
        wr(9'h0d2, 8'h01);
        chk({7'h00, INT}, 8'h00);
        wr(9'h0d6, 8'h00);
        rd(9'h0d6);
        chk(got, 8'h04);
        wr(9'h0d6, 8'h04);
        rd(9'h0d6);
        chk(got, 8'h00);
        wr(9'h0d2, 8'h09);
        frm.send_mf(1'b0, 5'd2, 4'h3);
        ind_rd(5'd2);
        chk(got, 8'h0a);
        wr(9'h0d2, 8'h00);
        frm.send_mf(1'b0, 5'd2, 4'h9);
        ind_rd(5'd2);
        chk(got, 8'h04);
        // Trunk code for channel 3 goes into the second payload bank.
        op(1'b1, 1'b0, 9'h0cf, 8'h3c);
        wr(9'h0ce, 8'h23);
        foreach (modes[i]) begin
            wr(9'h0d0, modes[i][23:16]);
            wr(9'h0d1, modes[i][15:8]);
            frm.drive(1'b0, 5'd2, 5'd3, 8'h11);
            frm.rest();
            chk(out_q, modes[i][7:0]);
        end
        // Payload read back, then fixed buffer and conditioning entries for channel 3.
        wr(9'h0ce, 8'ha3);
        rd(9'h0cf);
        chk(got, 8'h3c);
        op(1'b1, 1'b0, 9'h0d5, 8'h0f);
        wr(9'h0d4, 8'h03);
        op(1'b1, 1'b0, 9'h0cf, 8'h06);
        wr(9'h0ce, 8'h43);
        // Snapshot still holds the frame-1 copy, the stored entry is now all ones.
        foreach (sigs[i]) begin
            wr(9'h0d0, sigs[i][23:16]);
            wr(9'h0d1, sigs[i][15:8]);
            frm.drive(1'b0, 5'd2, 5'd3, 8'h11);
            frm.rest();
            chk(sig_q, sigs[i][7:0]);
        end
        // Filter: a new codeword lands only when it repeats.
        wr(9'h0d2, 8'h05);
        frm.send_mf(1'b0, 5'd2, 4'h3);
        ind_rd(5'd2);
        chk(got, 8'h0f);
        frm.send_mf(1'b0, 5'd2, 4'h3);
        ind_rd(5'd2);
        chk(got, 8'h03);
        wrap_up();
    end
endmodule
